//--- rtl/sfp_front_end.sv
// serial flash slave: spi framing, protection, power modes and array
//
// Functional notes
// R01 - output bit changes after each clock fall
// R02 - input bits sampled on clock rise
// R03 - deselect tri-states output, standby when idle
// R04 - no instruction before first select fall
// R05 - master uses clock mode 0 or 3
// R06 - page write 1..128 bytes, clears bits only
// R07 - master sends enable then page write
// R08 - block and chip clear set bytes ff
// R09 - busy flag shows running internal cycle
// R10 - stay active until internal cycles finish
// R11 - deep sleep ignores all but wake
// R12 - guard bits select protected sectors
// R13 - chip clear only with guard bits zero
// R14 - modify commands need whole byte count
// R15 - modify commands need write latch set
// R16 - latch clears on reset and completions
// R17 - hard guard freezes lock and guard bits
// R18 - pause begins with clock low
// R19 - pause ends with clock low
// R20 - pause tri-states, freezes counts, cycle continues
// R21 - deselect during pause resets interface
// R22 - master drives protect and pause pins
// R23 - hard guard rejects status write
// R24 - most significant bit first
// R25 - decode the ten command codes
// R26 - busy reads one while cycle runs
`timescale 1ns/10ps
module sfp_front_end
    import sfp_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst_b,
    input  wire sfp_pins_s pins,
    output logic           dout,
    output logic           dout_oe_b,
    output logic           busy_flag,
    output sfp_pwr_e       pwr_mode
);

    typedef struct packed {
        sfp_pins_s  p1;
        sfp_pins_s  p2;
        sfp_pins_s  p3;
        sfp_pins_s  pf;
        logic       armed;
        logic       sel;
        logic       paused;
        logic [2:0] bitc;
        logic [2:0] bytec;
        logic [7:0] dcnt;
        logic [7:0] shin;
        logic [7:0] op;
        logic [23:0] addr;
        logic [7:0] wdat;
        logic [7:0] tx_nxt;
        logic [7:0] tx_sh;
        logic       tx_pend;
        logic       tx_on;
        logic       write_latch_flag;
        logic [1:0] guard;
        logic       status_lock_bit;
        logic       sleep;
        sfp_job_e   job;
        logic [16:0] base;
        logic [16:0] walk;
        logic [16:0] last;
        logic [127:0] mask;
        logic       dout;
        logic       dout_oe_b;
        logic       busy_flag;
        sfp_pwr_e   pwr_mode;
    } sfp_state_s;

    sfp_state_s st;
    sfp_state_s next_st;

    logic [7:0] mem [0:MEM_BYTES-1];
    logic [7:0] pbuf [0:PAGE_BYTES-1];
    logic        mem_we;
    logic [16:0] mem_wa;
    logic [7:0]  mem_wd;
    logic        pb_we;
    logic [6:0]  pb_wa;
    logic [7:0]  pb_wd;

    // true when the sector holding the address is guarded
    function automatic logic guarded(input logic [1:0] g, input logic [16:0] a);
        logic [1:0] sec;
        sec = a[16:15];
        case (g)
            2'h1:    guarded = (sec == 2'h3); // R12
            2'h2:    guarded = sec[1]; // R12
            2'h3:    guarded = 1'b1; // R12
            default: guarded = 1'b0; // R12
        endcase
    endfunction

    // assembled status byte
    function automatic logic [7:0] status_byte(input sfp_state_s s);
        logic [7:0] v;
        v = 8'h00;
        v[ST_BUSY] = (s.job != SFP_IDLE); // R26
        v[ST_WLATCH] = s.write_latch_flag;
        v[ST_GUARD +: 2] = s.guard;
        v[ST_LOCK] = s.status_lock_bit;
        return v;
    endfunction

    logic        sck_r;
    logic        sck_f;
    logic        cs_fall;
    logic        cs_rise;
    logic        live;
    logic        hard_guard_mode;
    logic        aligned;
    logic [7:0]  b;
    logic [16:0] a_cur;
    logic [16:0] wa;

    // next state: pin sampling, framing, execution and internal cycles
    always_comb begin
        next_st = st;
        mem_we = 1'b0;
        mem_wa = 17'h0;
        mem_wd = 8'h00;
        pb_we = 1'b0;
        pb_wa = 7'h0;
        pb_wd = 8'h00;
        b = 8'h00;
        a_cur = 17'h0;
        wa = 17'h0;
        // three stage sampling; a level counts once stages two and three agree
        next_st.p1 = pins;
        next_st.p2 = st.p1;
        next_st.p3 = st.p2;
        next_st.pf = (st.p2 & st.p3) | (st.pf & (st.p2 ^ st.p3));
        sck_r = next_st.pf.sck & ~st.pf.sck;
        sck_f = ~next_st.pf.sck & st.pf.sck;
        cs_fall = st.pf.cs_b & ~next_st.pf.cs_b;
        cs_rise = ~st.pf.cs_b & next_st.pf.cs_b;
        hard_guard_mode = st.status_lock_bit & ~st.pf.wp_b; // R23
        aligned = (st.bitc == 3'h0); // R14

        // select falling edge opens a frame and arms the device
        if (cs_fall) begin
            next_st.armed = 1'b1; // R04
            next_st.sel = 1'b1;
            next_st.paused = 1'b0;
            next_st.bitc = 3'h0;
            next_st.bytec = 3'h0;
            next_st.dcnt = 8'h00;
            next_st.tx_on = 1'b0;
            next_st.tx_pend = 1'b0;
            next_st.mask = '0;
        end

        // pause enters or leaves only while the clock is low
        if (st.sel && !next_st.pf.cs_b && !next_st.pf.sck) begin
            if (!st.paused && !next_st.pf.hold_b) begin
                next_st.paused = 1'b1; // R18
            end else if (st.paused && next_st.pf.hold_b) begin
                next_st.paused = 1'b0; // R19
            end
        end

        live = st.sel && st.armed && !st.paused && !next_st.pf.cs_b; // R20

        // rising clock edge shifts one input bit in
        if (live && sck_r) begin
            b = {st.shin[6:0], next_st.pf.din}; // R24
            next_st.shin = b; // R02
            next_st.bitc = st.bitc + 3'h1;
            if (st.bitc == 3'h7) begin
                if (st.bytec != 3'h7) begin
                    next_st.bytec = st.bytec + 3'h1;
                end
                if (st.bytec == 3'h0) begin
                    next_st.op = b;
                end else if (st.bytec <= 3'h3 && st.op != CMD_STATUS_WRITE) begin
                    next_st.addr = {st.addr[15:0], b}; // R24
                end else if (st.bytec == 3'h1) begin
                    next_st.wdat = b;
                end
                // page data wraps inside the page, last 128 bytes kept
                if (st.op == CMD_PAGE_WRITE && st.bytec >= 3'h4) begin
                    pb_we = 1'b1;
                    pb_wa = 7'(st.addr[6:0] + st.dcnt[6:0]); // R06
                    pb_wd = b;
                    next_st.mask[pb_wa] = 1'b1;
                    next_st.dcnt = st.dcnt + 8'h01;
                end
                // prepare the next outgoing byte
                if (!st.sleep && (st.bytec == 3'h0 ? b : st.op) == CMD_STATUS_READ) begin
                    next_st.tx_nxt = status_byte(st); // R09
                    next_st.tx_pend = 1'b1;
                end else if (!st.sleep && st.op == CMD_READ && st.bytec >= 3'h3
                             && st.job == SFP_IDLE) begin
                    a_cur = (st.bytec == 3'h3) ? {st.addr[8:0], b} : st.addr[16:0];
                    next_st.tx_nxt = mem[a_cur];
                    next_st.addr = {7'h00, 17'(a_cur + 17'h1)};
                    next_st.tx_pend = 1'b1;
                end
            end
        end

        // falling clock edge moves one output bit
        if (live && sck_f) begin
            if (st.tx_pend) begin
                next_st.dout = st.tx_nxt[7]; // R01
                next_st.tx_sh = {st.tx_nxt[6:0], 1'b0}; // R24
                next_st.tx_on = 1'b1;
                next_st.tx_pend = 1'b0;
            end else if (st.tx_on) begin
                next_st.dout = st.tx_sh[7]; // R01
                next_st.tx_sh = {st.tx_sh[6:0], 1'b0};
            end
        end

        // internal cycle walks its address range one byte per clock
        if (st.job != SFP_IDLE) begin
            wa = st.base | st.walk;
            case (st.job)
                SFP_PROG: begin
                    mem_we = st.mask[st.walk[6:0]];
                    mem_wa = wa;
                    mem_wd = mem[wa] & pbuf[st.walk[6:0]]; // R06
                end
                SFP_SECT, SFP_CHIP: begin
                    mem_we = 1'b1;
                    mem_wa = wa;
                    mem_wd = ERASED; // R08
                end
                default: mem_we = 1'b0;
            endcase
            next_st.walk = st.walk + 17'h1;
            if (st.walk == st.last) begin
                next_st.job = SFP_IDLE; // R26
            end
        end

        // select rising edge closes the frame and executes the command
        if (cs_rise && st.sel) begin
            next_st.sel = 1'b0;
            next_st.paused = 1'b0;
            next_st.tx_on = 1'b0;
            next_st.tx_pend = 1'b0;
            // a frame ended during pause is dropped
            if (!st.paused && st.armed && st.bytec != 3'h0) begin // R21
                if (st.sleep) begin
                    if (st.op == CMD_WAKE) begin
                        next_st.sleep = 1'b0; // R11
                    end
                end else if (st.job == SFP_IDLE) begin
                    case (st.op) // R25
                        CMD_ALLOW_WRITE:    next_st.write_latch_flag = 1'b1; // R15
                        CMD_DISALLOW_WRITE: next_st.write_latch_flag = 1'b0; // R16
                        CMD_DEEP_SLEEP:     next_st.sleep = 1'b1; // R11
                        CMD_STATUS_WRITE: begin
                            if (aligned && st.bytec >= 3'h2) begin // R14
                                next_st.write_latch_flag = 1'b0; // R16
                                if (st.write_latch_flag && !hard_guard_mode) begin // R15 R23
                                    next_st.status_lock_bit = st.wdat[ST_LOCK]; // R17
                                    next_st.guard = st.wdat[ST_GUARD +: 2]; // R17
                                    next_st.job = SFP_STAT;
                                    next_st.base = 17'h0;
                                    next_st.walk = 17'h0;
                                    next_st.last = STAT_WR_LAST;
                                end
                            end
                        end
                        CMD_PAGE_WRITE: begin
                            if (aligned && st.bytec >= 3'h5) begin // R14 R06
                                next_st.write_latch_flag = 1'b0; // R16
                                if (st.write_latch_flag
                                    && !guarded(st.guard, st.addr[16:0])) begin // R15 R12
                                    next_st.job = SFP_PROG;
                                    next_st.base = {st.addr[16:7], 7'h00};
                                    next_st.walk = 17'h0;
                                    next_st.last = PAGE_LAST;
                                end
                            end
                        end
                        CMD_BLOCK_CLEAR: begin
                            if (aligned && st.bytec == 3'h4) begin // R14
                                next_st.write_latch_flag = 1'b0; // R16
                                if (st.write_latch_flag
                                    && !guarded(st.guard, st.addr[16:0])) begin // R15 R12
                                    next_st.job = SFP_SECT;
                                    next_st.base = {st.addr[16:15], 15'h0000};
                                    next_st.walk = 17'h0;
                                    next_st.last = SECT_LAST;
                                end
                            end
                        end
                        CMD_CHIP_CLEAR: begin
                            if (aligned && st.bytec == 3'h1) begin // R14
                                next_st.write_latch_flag = 1'b0; // R16
                                if (st.write_latch_flag && st.guard == 2'h0) begin // R15 R13
                                    next_st.job = SFP_CHIP;
                                    next_st.base = 17'h0;
                                    next_st.walk = 17'h0;
                                    next_st.last = CHIP_LAST;
                                end
                            end
                        end
                        default: next_st.job = st.job;
                    endcase
                end
            end
        end

        // registered outputs
        next_st.dout_oe_b = ~(next_st.sel && !next_st.paused && next_st.tx_on
                              && !next_st.pf.cs_b); // R03 R20
        next_st.busy_flag = (next_st.job != SFP_IDLE); // R09
        if (next_st.sleep) begin
            next_st.pwr_mode = SFP_DEEP;
        end else if (!next_st.pf.cs_b || next_st.job != SFP_IDLE) begin
            next_st.pwr_mode = SFP_ACTIVE; // R10
        end else begin
            next_st.pwr_mode = SFP_STANDBY; // R03
        end
    end

    // reset release synchroniser
    logic [1:0] rst_pipe;
    logic       rst_sync_b;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_b = rst_pipe[1];

    // state register
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st <= '0; // pins read low, so a select held low needs a real fall R04
            st.guard <= GUARD_RST;
            st.status_lock_bit <= LOCK_RST;
            st.job <= SFP_IDLE;
            st.dout_oe_b <= 1'b1;
            st.pwr_mode <= SFP_STANDBY;
        end else begin
            st <= next_st;
        end
    end

    // array and page buffer storage
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
        if (pb_we) begin
            pbuf[pb_wa] <= pb_wd;
        end
    end

    assign dout = st.dout;
    assign dout_oe_b = st.dout_oe_b;
    assign busy_flag = st.busy_flag;
    assign pwr_mode = st.pwr_mode;

endmodule

//--- shared/sfp_pkg.sv
// package of constants and types for the serial flash protect front end
package sfp_pkg;
    localparam int unsigned CLK_MHZ      = 200;
    localparam int unsigned MEM_BYTES    = 131072;
    localparam int unsigned PAGE_BYTES   = 128;
    localparam logic [16:0] PAGE_LAST    = 17'h0007f;
    localparam logic [16:0] SECT_LAST    = 17'h07fff;
    localparam logic [16:0] CHIP_LAST    = 17'h1ffff;
    localparam int unsigned STAT_WR_NS   = 100;
    localparam logic [16:0] STAT_WR_LAST = 17'((STAT_WR_NS * CLK_MHZ + 999) / 1000 - 1);
    localparam logic [7:0]  ERASED       = 8'hff;
    // command codes
    localparam logic [7:0] CMD_ALLOW_WRITE    = 8'h06;
    localparam logic [7:0] CMD_DISALLOW_WRITE = 8'h04;
    localparam logic [7:0] CMD_STATUS_READ    = 8'h05;
    localparam logic [7:0] CMD_STATUS_WRITE   = 8'h01;
    localparam logic [7:0] CMD_READ           = 8'h03;
    localparam logic [7:0] CMD_PAGE_WRITE     = 8'h02;
    localparam logic [7:0] CMD_BLOCK_CLEAR    = 8'hd8;
    localparam logic [7:0] CMD_CHIP_CLEAR     = 8'hc7;
    localparam logic [7:0] CMD_DEEP_SLEEP     = 8'hb9;
    localparam logic [7:0] CMD_WAKE           = 8'hab;
    // status byte bit positions
    localparam int unsigned ST_BUSY  = 0;
    localparam int unsigned ST_WLATCH = 1;
    localparam int unsigned ST_GUARD = 2;
    localparam int unsigned ST_LOCK  = 7;
    // reset values of the retained status bits
    localparam logic [1:0] GUARD_RST = 2'h0;
    localparam logic       LOCK_RST  = 1'h0;
    typedef enum logic [1:0] {SFP_STANDBY, SFP_ACTIVE, SFP_DEEP} sfp_pwr_e;
    typedef enum logic [2:0] {SFP_IDLE, SFP_PROG, SFP_SECT, SFP_CHIP, SFP_STAT} sfp_job_e;
    // pins arriving from the master
    typedef struct packed {
        logic sck;
        logic cs_b;
        logic din;
        logic hold_b;
        logic wp_b;
    } sfp_pins_s;
endpackage

//--- bench/sfp_front_end_asserts.sv
// concurrent checks on the pins of the serial flash front end
`timescale 1ns/10ps
module sfp_front_end_asserts
    import sfp_pkg::*;
(
    input wire logic      clk,
    input wire logic      rst_b,
    input wire sfp_pins_s pins,
    input wire logic      dout,
    input wire logic      dout_oe_b,
    input wire logic      busy_flag,
    input wire sfp_pwr_e  pwr_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // output released while deselected or paused
    a_oe_deselect: assert property (pins.cs_b [*6] |-> dout_oe_b)
        else $error("output driven while deselected");
    a_hold_tristate: assert property ((!pins.hold_b && !pins.sck && !pins.cs_b) [*6]
        |-> dout_oe_b)
        else $error("output driven during pause");
    // output moves only after a clock fall
    a_sck_high_stable: assert property ((pins.sck && !pins.cs_b) [*6] |=> $stable(dout))
        else $error("output changed while clock high");
    // busy cycles and power modes
    a_busy_active: assert property (busy_flag |-> pwr_mode == SFP_ACTIVE)
        else $error("standby while busy");
    a_busy_rise_desel: assert property ($rose(busy_flag) |-> pins.cs_b)
        else $error("cycle started inside a frame");
    a_busy_min_len: assert property ($rose(busy_flag) |-> busy_flag [*8] ##1 busy_flag [*8])
        else $error("busy cycle too short");
    a_deep_quiet: assert property (pwr_mode == SFP_DEEP |-> !busy_flag && dout_oe_b)
        else $error("activity in deep sleep");
    a_deep_stays: assert property ((pwr_mode == SFP_DEEP && !pins.cs_b) [*4]
        |=> pwr_mode == SFP_DEEP)
        else $error("deep sleep left inside a frame");
    a_sel_active: assert property ($fell(pins.cs_b) ##1
        (!pins.cs_b && pwr_mode != SFP_DEEP) [*6] |-> pwr_mode == SFP_ACTIVE)
        else $error("selected device not active");
endmodule

bind sfp_front_end sfp_front_end_asserts u_chk (.clk(clk), .rst_b(rst_b), .pins(pins),
    .dout(dout), .dout_oe_b(dout_oe_b), .busy_flag(busy_flag), .pwr_mode(pwr_mode));

//--- bench/sfp_spi_master.sv
// behavioural serial bus master facing the flash front end
`timescale 1ns/10ps
module sfp_spi_master
    import sfp_pkg::*;
(
    input  wire logic clk,
    input  wire logic dout,
    input  wire logic dout_oe_b,
    output sfp_pins_s pins
);
    logic mode3;

    // all pins driven to defined levels; select held low since power-up
    initial begin
        pins = '{sck: 1'b0, cs_b: 1'b0, din: 1'b0, hold_b: 1'b1, wp_b: 1'b1};
        mode3 = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // idle clock level changes only between frames
    task automatic set_mode(input logic m);
        mode3 = m;
        pins.sck <= m;
        wait_clk(4);
    endtask

    task automatic set_wp(input logic v);
        pins.wp_b <= v;
        wait_clk(4);
    endtask

    // a falling select edge opens every frame but the first one of t_latch
    task automatic sel();
        pins.cs_b <= 1'b0;
        wait_clk(8);
    endtask

    task automatic desel();
        wait_clk(8);
        pins.cs_b <= 1'b1;
        pins.din <= ~pins.din;  // stale data must not look valid
        wait_clk(8);
    endtask

    // one bit of 80 ns; output sampled just before the rising edge
    task automatic xbit(input logic b, output logic q);
        if (mode3) pins.sck <= 1'b0;
        pins.din <= b;
        wait_clk(8);
        q = dout_oe_b ? 1'bz : dout;
        pins.sck <= 1'b1;
        wait_clk(8);
        if (!mode3) pins.sck <= 1'b0;
    endtask

    task automatic xfer(input logic [7:0] b, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) xbit(b[i], q[i]);
    endtask

    // pause with clock low, wiggle clock and data, then resume with clock low
    task automatic pause(output logic oe);
        pins.hold_b <= 1'b0;
        wait_clk(8);
        pins.sck <= 1'b1;
        pins.din <= ~pins.din;
        wait_clk(8);
        oe = dout_oe_b;
        pins.sck <= 1'b0;
        wait_clk(8);
        pins.hold_b <= 1'b1;
        wait_clk(8);
    endtask

    // deselect during a pause, then raise pause before the next select
    task automatic pause_abort();
        pins.hold_b <= 1'b0;
        wait_clk(8);
        pins.cs_b <= 1'b1;
        wait_clk(8);
        pins.hold_b <= 1'b1;
        wait_clk(8);
    endtask
endmodule

//--- bench/sfp_front_end_tb.sv
// self-checking bench for the serial flash front end
`timescale 1ns/10ps
module sfp_front_end_tb
    import sfp_pkg::*;
;
    logic      clk;
    logic      rst_b;
    sfp_pins_s pins;
    logic      dout;
    logic      dout_oe_b;
    logic      busy_flag;
    sfp_pwr_e  pwr_mode;
    int        err_total;
    int        checks;

    sfp_front_end DUT (.clk(clk), .rst_b(rst_b), .pins(pins), .dout(dout),
        .dout_oe_b(dout_oe_b), .busy_flag(busy_flag), .pwr_mode(pwr_mode));
    sfp_spi_master u_master (.clk(clk), .dout(dout), .dout_oe_b(dout_oe_b), .pins(pins));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cmd2(input logic [7:0] c, input int n, input logic [7:0] v);
        logic [7:0] q;
        u_master.sel();
        u_master.xfer(c, q);
        if (n > 0) u_master.xfer(v, q);
        u_master.desel();
    endtask

    task automatic cmd(input logic [7:0] c);
        cmd2(c, 0, 8'h00);
    endtask

    task automatic rd_stat(output logic [7:0] s);
        logic [7:0] q;
        u_master.sel();
        u_master.xfer(CMD_STATUS_READ, q);
        u_master.xfer(8'h00, s);
        u_master.desel();
    endtask

    // command, three address bytes, n data bytes, xb stray bits
    task automatic adr_frame(input logic [7:0] c, input logic [16:0] a, input int n,
                             input logic [15:0] d, input int xb);
        logic [23:0] a24;
        logic [7:0]  q;
        logic        b;
        a24 = {7'h00, a};
        u_master.sel();
        u_master.xfer(c, q);
        for (int i = 2; i >= 0; i--) u_master.xfer(a24[i*8 +: 8], q);
        if (n > 0) u_master.xfer(d[15:8], q);
        if (n > 1) u_master.xfer(d[7:0], q);
        for (int i = 0; i < xb; i++) u_master.xbit(1'b0, b);
        u_master.desel();
    endtask

    task automatic rd_mem(input logic [16:0] a, output logic [15:0] d);
        logic [23:0] a24;
        logic [7:0]  q;
        a24 = {7'h00, a};
        u_master.sel();
        u_master.xfer(CMD_READ, q);
        for (int i = 2; i >= 0; i--) u_master.xfer(a24[i*8 +: 8], q);
        u_master.xfer(8'h00, d[15:8]);
        u_master.xfer(8'h00, d[7:0]);
        u_master.desel();
    endtask

    task automatic wait_idle(input int lim);
        for (int i = 0; i < lim && busy_flag !== 1'b0; i++) @(posedge clk);
        chk({7'h0, busy_flag}, 8'h00);
    endtask

    // a frame before the first select fall, latch set and clear
    task automatic t_latch();
        logic [7:0] s;
        u_master.xfer(CMD_ALLOW_WRITE, s);
        u_master.desel();
        rd_stat(s);
        chk(s, 8'h00);
        cmd(CMD_ALLOW_WRITE);
        rd_stat(s);
        chk(s, 8'h02);
        cmd(CMD_DISALLOW_WRITE);
        rd_stat(s);
        chk(s, 8'h00);
        $display("t_latch done");
    endtask

    // sector clear, page program twice over one shared byte, stray bits refused
    task automatic t_array();
        logic [7:0]  s;
        logic [15:0] d;
        cmd(CMD_ALLOW_WRITE);
        adr_frame(CMD_BLOCK_CLEAR, 17'h00000, 0, 16'h0000, 0);
        chk({6'h0, pwr_mode}, {6'h0, SFP_ACTIVE});
        rd_stat(s);
        chk(s & 8'h01, 8'h01);
        wait_idle(33000);
        chk({6'h0, pwr_mode}, {6'h0, SFP_STANDBY});
        rd_mem(17'h00010, d);
        chk(d[15:8], ERASED);
        chk(d[7:0], ERASED);
        cmd(CMD_ALLOW_WRITE);
        adr_frame(CMD_PAGE_WRITE, 17'h00010, 2, 16'ha53c, 0);
        wait_idle(400);
        cmd(CMD_ALLOW_WRITE);
        adr_frame(CMD_PAGE_WRITE, 17'h00011, 1, 16'h0f00, 0);
        wait_idle(400);
        rd_mem(17'h00010, d);
        chk(d[15:8], 8'ha5);
        chk(d[7:0], 8'h0c);
        cmd(CMD_ALLOW_WRITE);
        adr_frame(CMD_PAGE_WRITE, 17'h00020, 1, 16'h0000, 3);
        chk({7'h0, busy_flag}, 8'h00);
        rd_stat(s);
        chk(s, 8'h02);
        $display("t_array done");
    endtask

    // every guard value against every sector, chip clear refused when guarded
    task automatic t_guard();
        logic [7:0] s;
        for (int g = 0; g < 4; g++) begin
            cmd(CMD_ALLOW_WRITE);
            cmd2(CMD_STATUS_WRITE, 1, 8'(g << 2));
            wait_idle(200);
            for (int sct = 0; sct < 4; sct++) begin
                cmd(CMD_ALLOW_WRITE);
                adr_frame(CMD_PAGE_WRITE, {sct[1:0], 15'h0100}, 1, 16'hff00, 0);
                chk({7'h0, busy_flag}, {7'h0, sct < 4 - ((g == 3) ? 4 : g)});
                wait_idle(400);
            end
            if (g != 0) begin
                cmd(CMD_ALLOW_WRITE);
                cmd(CMD_CHIP_CLEAR);
                chk({7'h0, busy_flag}, 8'h00);
                rd_stat(s);
                chk(s, 8'(g << 2));
            end
        end
        $display("t_guard done");
    endtask

    // lock bit with protect pin low freezes the status
    task automatic t_hard();
        logic [7:0] s;
        cmd(CMD_ALLOW_WRITE);
        cmd2(CMD_STATUS_WRITE, 1, 8'h84);
        wait_idle(200);
        u_master.set_wp(1'b0);
        cmd(CMD_ALLOW_WRITE);
        cmd2(CMD_STATUS_WRITE, 1, 8'h00);
        chk({7'h0, busy_flag}, 8'h00);
        rd_stat(s);
        chk(s, 8'h84);
        u_master.set_wp(1'b1);
        cmd(CMD_ALLOW_WRITE);
        cmd2(CMD_STATUS_WRITE, 1, 8'h00);
        wait_idle(200);
        rd_stat(s);
        chk(s, 8'h00);
        $display("t_hard done");
    endtask

    // deep sleep ignores all but wake
    task automatic t_sleep();
        logic [7:0] s;
        cmd(CMD_DEEP_SLEEP);
        chk({6'h0, pwr_mode}, {6'h0, SFP_DEEP});
        cmd(CMD_ALLOW_WRITE);
        rd_stat(s);
        chk(s, 8'hzz);
        cmd(CMD_WAKE);
        chk({6'h0, pwr_mode}, {6'h0, SFP_STANDBY});
        rd_stat(s);
        chk(s, 8'h00);
        $display("t_sleep done");
    endtask

    // pause inside a status byte, then a deselect during pause drops a frame
    task automatic t_pause();
        logic [7:0] s;
        logic       b;
        cmd(CMD_ALLOW_WRITE);
        u_master.sel();
        u_master.xfer(CMD_STATUS_READ, s);
        for (int i = 7; i >= 4; i--) u_master.xbit(1'b0, s[i]);
        u_master.pause(b);
        chk({7'h0, b}, 8'h01);
        for (int i = 3; i >= 0; i--) u_master.xbit(1'b0, s[i]);
        u_master.desel();
        chk(s, 8'h02);
        u_master.sel();
        u_master.xfer(CMD_DISALLOW_WRITE, s);
        u_master.pause_abort();
        rd_stat(s);
        chk(s, 8'h02);
        $display("t_pause done");
    endtask

    // same traffic with the clock idling high
    task automatic t_mode3();
        logic [7:0] s;
        u_master.set_mode(1'b1);
        rd_stat(s);
        chk(s, 8'h02);
        cmd(CMD_DISALLOW_WRITE);
        rd_stat(s);
        chk(s, 8'h00);
        u_master.set_mode(1'b0);
        $display("t_mode3 done");
    endtask

    // reset, then the scenarios in order
    initial begin
        rst_b = 1'b0;
        err_total = 0;
        checks = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        chk({dout_oe_b, busy_flag, 4'h0, pwr_mode}, {2'h2, 4'h0, SFP_ACTIVE});
        t_latch();
        t_array();
        t_guard();
        t_hard();
        t_sleep();
        t_pause();
        t_mode3();
        end_of_test();
    end

    // watchdog about 30 percent beyond the expected run length
    initial begin
        #400us;
        err_total++;
        end_of_test();
    end
endmodule
